// ### shared/radio_cfg_defs.svh
// Constants for the radio serial configuration port.
// Assumes a 25 MHz system clock; included by bare name.
`ifndef RADIO_CFG_DEFS_SVH
`define RADIO_CFG_DEFS_SVH

// Serial word layout
`define WORD_BITS      32
`define CTRL_BITS      4
`define LATCH_COUNT    16
`define PORT_MODE_BIT  28
`define VARIANT_HI     19
`define VARIANT_LO     17
`define VARIANT_SPI    3'h7

// Latch addresses with side effects
`define CFG_LATCH      4'h0
`define VARIANT_LATCH  4'hf
`define READBACK_LATCH 4'h7
`define SYNC_LATCH     4'hb

// Sync word field inside its latch
`define SYNC_HI        31
`define SYNC_LO        8
`define SYNC_BITS      24

// Readback word width
`define RB_BITS        16

// Timing: times in ns, counts derived at the 40 ns clock
`define CLK_PERIOD_NS  40
`define BIT_TIME_NS    2560
`define BIT_CYCLES     (`BIT_TIME_NS / `CLK_PERIOD_NS)
`define REF_HALF_NS    80
`define REF_HALF_CYC   (`REF_HALF_NS / `CLK_PERIOD_NS)
`define CNT_BITS       8

`endif

// ### shared/radio_cfg_pkg.sv
// Types shared by the radio serial configuration port.
// Assumes radio_cfg_defs.svh is on the include path.
`include "radio_cfg_defs.svh"

package radio_cfg_pkg;

  typedef logic [`WORD_BITS-1:0] cfg_word_t;
  typedef logic [`LATCH_COUNT-1:0][`WORD_BITS-1:0] latch_bank_t;
  typedef logic [`CNT_BITS-1:0] count_t;

  // Complete state of the top module
  typedef struct packed {
    latch_bank_t             bank;
    cfg_word_t               shift;
    logic [`RB_BITS-1:0]     rb_shift;
    logic                    rb_out;
    cfg_word_t               cfg_word;
    logic                    uart;
    logic                    spi;
    count_t                  bit_cnt;
    logic                    bit_clk;
    count_t                  ref_cnt;
    logic                    ref_clk;
    logic                    prev_rx;
    logic [`SYNC_BITS-1:0]   rx_hist;
    logic                    sync_hit;
    logic                    sym_phase;
    logic                    sym_msb;
    logic [1:0]              sym;
    logic                    sym_valid;
    logic                    tx_bit;
    logic                    rx_data;
    logic                    data_out;
    logic                    data_oe;
    logic                    bclk_out;
    logic                    bclk_oe;
    logic                    ref_out;
  } port_state_s;

endpackage

// ### shared/pin_sync_if.sv
// Carrier between the pin filter and the port logic.
// Assumes all signals sit in the clk domain except raw.
`timescale 1ns/1ps
`default_nettype none

interface pin_sync_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] level;
  logic [W-1:0] rise;
  logic [W-1:0] fall;
  modport filter (input raw, output level, output rise, output fall);
  modport user (output raw, input level, input rise, input fall);
endinterface

`default_nettype wire

// ### logic/pin_filter.sv
// Three-stage synchroniser and agreement filter for W pins.
// Assumes raw pins are asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none

module pin_filter #(parameter int W = 1) (
  // Clock and reset
  input wire logic     clk,
  input wire logic     rst_b,
  // Pins in, filtered levels and edges out
  pin_sync_if.filter   pins
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] level;
    logic [W-1:0] rise;
    logic [W-1:0] fall;
  } filt_state_s;

  filt_state_s q;
  filt_state_s next_q;

  // Level moves only when stages two and three agree; s1 feeds s2 alone
  always_comb begin
    next_q       = q;
    next_q.s1    = pins.raw;
    next_q.s2    = q.s1;
    next_q.s3    = q.s2;
    next_q.level = (q.s2 == q.s3) ? q.s2 : q.level;
    next_q.rise  = next_q.level & ~q.level;
    next_q.fall  = ~next_q.level & q.level;
  end

  // State register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign pins.level = q.level;
  assign pins.rise  = q.rise;
  assign pins.fall  = q.fall;

endmodule

`default_nettype wire

// ### logic/radio_serial_config_port.sv
// Serial configuration and data-port logic of a narrow-band radio.
// Assumes a 25 MHz clk; host pins are asynchronous and filtered here.
`timescale 1ns/1ps
`default_nettype none
`include "radio_cfg_defs.svh"

// Functional notes
// - Words arrive MSB first; low four bits choose the target latch.
// - Each serial clock rising edge shifts one data bit into 32-bit register.
// - Strobe rising loads the shift register into the addressed latch only.
// - Host clocks readback bits out one per serial clock rising edge.
// - Chip enable low clears every latch and all port state.
// - Latch 0 bit 28 set selects UART data-port mode.
// - UART bit set and latch 15 bits 19:17 equal 7 selects SPI.
// - In UART/SPI the data clock leaves on the divided reference pin.
// - 4FSK symbol MSB/LSB phase is aligned by the sync word match.
// - UART/SPI data pin drives receive data, floats in transmit.
// - UART/SPI transmit data enters on clock pin; receive leaves it floating.
// - Sync detect output rises when programmed sync word is matched.
// - Normal receive data clock rises at the centre of each bit.
module radio_serial_config_port (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  // Host serial interface pins
  input  wire logic                  serial_clock,
  input  wire logic                  serial_word_input,
  input  wire logic                  latch_load_strobe,
  input  wire logic                  chip_enable,
  output logic                       readback_output,
  // Radio data and clock pins, three signals each; reference and sync outputs
  input  wire logic                  radio_data_pin_in,
  output logic                       radio_data_pin_out,
  output logic                       radio_data_pin_oe,
  input  wire logic                  radio_bit_clock_pin_in,
  output logic                       radio_bit_clock_pin_out,
  output logic                       radio_bit_clock_pin_oe,
  output logic                       divided_reference_output,
  output logic                       sync_detect,
  // Core side
  input  wire logic                  radio_transmit,
  input  wire logic                  fsk4_mode,
  input  wire logic                  demod_bit,
  input  wire logic [`RB_BITS-1:0]   readback_value,
  input  wire logic [`CTRL_BITS-1:0] cfg_sel,
  output logic [`WORD_BITS-1:0]      cfg_word,
  output logic                       uart_mode,
  output logic                       spi_mode,
  output logic                       tx_bit,
  output logic [1:0]                 fsk4_symbol,
  output logic                       fsk4_symbol_valid
);

  localparam radio_cfg_pkg::count_t BIT_LAST = radio_cfg_pkg::count_t'(`BIT_CYCLES - 1);
  localparam radio_cfg_pkg::count_t BIT_MID  = radio_cfg_pkg::count_t'(`BIT_CYCLES / 2);
  localparam radio_cfg_pkg::count_t REF_LAST = radio_cfg_pkg::count_t'(`REF_HALF_CYC - 1);

  radio_cfg_pkg::port_state_s q;
  radio_cfg_pkg::port_state_s next_q;

  // Host pins: 0 sclk, 1 data, 2 strobe, 3 enable; radio pins: 0 data, 1 clock
  pin_sync_if #(.W(4)) host ();
  pin_sync_if #(.W(2)) radio ();

  assign host.raw  = {chip_enable, latch_load_strobe, serial_word_input, serial_clock};
  assign radio.raw = {radio_bit_clock_pin_in, radio_data_pin_in};

  pin_filter #(.W(4)) u_host_filter (
    .clk   (clk),
    .rst_b (rst_b),
    .pins  (host)
  );

  pin_filter #(.W(2)) u_radio_filter (
    .clk   (clk),
    .rst_b (rst_b),
    .pins  (radio)
  );

  logic                    port_mode;
  logic [`CTRL_BITS-1:0]   addr;
  logic [`SYNC_BITS-1:0]   hist_now;
  radio_cfg_pkg::count_t   cnt_now;
  logic                    centre;

  // Next-state logic for the whole port
  always_comb begin
    next_q    = q;
    port_mode = q.uart;
    addr      = q.shift[`CTRL_BITS-1:0];
    hist_now  = {q.rx_hist[`SYNC_BITS-2:0], demod_bit};
    cnt_now   = '0;
    centre    = 1'b0;
    next_q.sym_valid = 1'b0;

    // Serial shift and readback, one bit per serial clock rise
    // The loaded MSB already stands on the pin, so each rise shows the next bit
    if (host.rise[0]) begin
      next_q.shift    = {q.shift[`WORD_BITS-2:0], host.level[1]};
      next_q.rb_shift = {q.rb_shift[`RB_BITS-2:0], 1'b0};
      next_q.rb_out   = q.rb_shift[`RB_BITS-2];
    end

    // Only the strobe rise and power-down touch the latches; shifting leaves them alone
    if (host.rise[2]) begin
      next_q.bank[addr] = q.shift;
      if (addr == `READBACK_LATCH) begin
        next_q.rb_shift = readback_value;
        next_q.rb_out   = readback_value[`RB_BITS-1];
      end
    end

    // Mode decode from the live latches
    next_q.uart = q.bank[`CFG_LATCH][`PORT_MODE_BIT];
    next_q.spi  = q.bank[`CFG_LATCH][`PORT_MODE_BIT] &&
                  (q.bank[`VARIANT_LATCH][`VARIANT_HI:`VARIANT_LO] == `VARIANT_SPI);
    next_q.cfg_word = q.bank[cfg_sel];

    // Reference divider, 50:50 mark-space
    if (q.ref_cnt == REF_LAST) begin
      next_q.ref_cnt = '0;
      next_q.ref_clk = ~q.ref_clk;
    end else begin
      next_q.ref_cnt = q.ref_cnt + 1'b1;
    end

    // Bit timer restarts on a received transition so the clock rise sits mid-bit
    next_q.prev_rx = demod_bit;
    if (!radio_transmit && (demod_bit != q.prev_rx)) begin
      cnt_now = '0;
    end else if (q.bit_cnt == BIT_LAST) begin
      cnt_now = '0;
    end else begin
      cnt_now = q.bit_cnt + 1'b1;
    end
    next_q.bit_cnt = cnt_now;
    next_q.bit_clk = (cnt_now >= BIT_MID);
    centre = (cnt_now == BIT_MID) && (q.bit_cnt != BIT_MID);

    // Receive data presented at the bit boundary, stable across the centre
    if (!radio_transmit && cnt_now == '0) begin
      next_q.rx_data = demod_bit;
    end

    // Receive sampling, sync search and 4FSK symbol pairing
    if (!radio_transmit && centre) begin
      next_q.rx_hist = hist_now;
      if (hist_now == q.bank[`SYNC_LATCH][`SYNC_HI:`SYNC_LO]) begin
        next_q.sync_hit  = 1'b1;
        next_q.sym_phase = 1'b0;
      end else if (fsk4_mode && !q.sym_phase) begin
        next_q.sym_msb   = demod_bit;
        next_q.sym_phase = 1'b1;
      end else if (fsk4_mode) begin
        next_q.sym       = {q.sym_msb, demod_bit};
        next_q.sym_valid = 1'b1;
        next_q.sym_phase = 1'b0;
      end
    end

    // Rewriting the sync word rearms the detector; a match in that cycle wins
    if (host.rise[2] && addr == `SYNC_LATCH && !next_q.sync_hit) begin
      next_q.sync_hit = 1'b0;
    end else if (host.rise[2] && addr == `SYNC_LATCH && !(centre && !radio_transmit &&
                 hist_now == q.bank[`SYNC_LATCH][`SYNC_HI:`SYNC_LO])) begin
      next_q.sync_hit = 1'b0;
    end

    // Transmit data taken at the clock centre from the mode's input pin
    if (radio_transmit && centre) begin
      next_q.tx_bit = port_mode ? radio.level[1] : radio.level[0];
    end

    // Pin drivers
    next_q.data_out = q.rx_data;
    next_q.data_oe  = !radio_transmit;
    next_q.bclk_out = q.bit_clk;
    next_q.bclk_oe  = !port_mode;
    next_q.ref_out  = port_mode ? q.bit_clk : q.ref_clk;

    // Power-down loses every setting; host must reprogram afterwards
    if (!host.level[3]) begin
      next_q = '0;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  // Outputs straight from the state register
  assign readback_output          = q.rb_out;
  assign radio_data_pin_out       = q.data_out;
  assign radio_data_pin_oe        = q.data_oe;
  assign radio_bit_clock_pin_out  = q.bclk_out;
  assign radio_bit_clock_pin_oe   = q.bclk_oe;
  assign divided_reference_output = q.ref_out;
  assign sync_detect              = q.sync_hit;
  assign cfg_word                 = q.cfg_word;
  assign uart_mode                = q.uart;
  assign spi_mode                 = q.spi;
  assign tx_bit                   = q.tx_bit;
  assign fsk4_symbol              = q.sym;
  assign fsk4_symbol_valid        = q.sym_valid;

endmodule

`default_nettype wire

// ### logic/unused_placeholder_none.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ### verif/radio_cfg_monitor.sv
// Port checker for the radio serial configuration port.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
`include "radio_cfg_defs.svh"

module radio_cfg_monitor (
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  rst_b,
  // Host pins
  input wire logic                  latch_load_strobe,
  input wire logic                  serial_clock,
  input wire logic                  chip_enable,
  input wire logic                  readback_output,
  // Data port and modes
  input wire logic                  radio_transmit,
  input wire logic                  radio_data_pin_oe,
  input wire logic                  radio_bit_clock_pin_oe,
  input wire logic                  uart_mode,
  input wire logic                  spi_mode,
  input wire logic                  sync_detect,
  input wire logic [`WORD_BITS-1:0] cfg_word,
  input wire logic                  fsk4_symbol_valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // Modes move only after a strobe or a power-down, never while bits shift
  property p_hold;
    (chip_enable && !latch_load_strobe)[*8] |=> $stable(uart_mode) && $stable(spi_mode);
  endproperty
  a_hold: assert property (p_hold) else $error("mode changed without strobe");
  property p_spi;
    spi_mode |-> uart_mode;
  endproperty
  a_spi: assert property (p_spi) else $error("spi mode without uart bit");
  property p_tx_float;
    (uart_mode && radio_transmit)[*3] |-> !radio_data_pin_oe;
  endproperty
  a_tx_float: assert property (p_tx_float) else $error("data pin driven in transmit");
  property p_rx_drive;
    (uart_mode && !radio_transmit)[*3] |-> radio_data_pin_oe;
  endproperty
  a_rx_drive: assert property (p_rx_drive) else $error("data pin idle in receive");
  property p_clk_pin;
    uart_mode[*3] |-> !radio_bit_clock_pin_oe;
  endproperty
  a_clk_pin: assert property (p_clk_pin) else $error("clock pin driven in uart");
  // The filter delays chip enable, so allow eight cycles
  property p_off;
    (!chip_enable)[*8] |-> !uart_mode && !spi_mode && !sync_detect && cfg_word == 32'h0;
  endproperty
  a_off: assert property (p_off) else $error("state kept while powered down");
  property p_rb;
    (chip_enable && !serial_clock && !latch_load_strobe)[*6] |=> $stable(readback_output);
  endproperty
  a_rb: assert property (p_rb) else $error("readback moved without clock");
  property p_sym;
    fsk4_symbol_valid |=> !fsk4_symbol_valid;
  endproperty
  a_sym: assert property (p_sym) else $error("symbol strobe longer than one cycle");
endmodule

`default_nettype wire

// ### verif/host_serial_model.sv
// Host model that writes words and clocks readback bits.
// Assumes the device filters each pin over about four clocks.
`timescale 1ns/1ps
`default_nettype none

module host_serial_model (
  // Clock
  input wire logic clk,
  // Serial pins toward the device
  output var logic serial_clock,
  output var logic serial_word_input,
  output var logic latch_load_strobe
);
  // Idle levels from time zero
  initial begin
    serial_clock = 1'b0;
    serial_word_input = 1'b0;
    latch_load_strobe = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Each level held four clocks so the pin filter cannot drop it
  task automatic pulse(input logic d);
    serial_word_input <= d;
    hold(4);
    serial_clock <= 1'b1;
    hold(4);
    serial_clock <= 1'b0;
  endtask
  // Whole word MSB first, then strobe; data left inverted after
  task automatic write_word(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      pulse(w[i]);
    end
    hold(4);
    latch_load_strobe <= 1'b1;
    hold(4);
    latch_load_strobe <= 1'b0;
    serial_word_input <= ~w[0];
    hold(4);
  endtask
endmodule

`default_nettype wire

// ### verif/testbench.sv
// Self-checking bench for the radio serial configuration port.
// Assumes the host model and the checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
`include "radio_cfg_defs.svh"

module testbench;
  // Drives and observed outputs
  logic                  clk = 1'b0;
  logic                  rst_b = 1'b0;
  logic                  chip_enable = 1'b1;
  logic                  radio_transmit = 1'b0;
  logic [`RB_BITS-1:0]   readback_value = 16'h0000;
  logic [`CTRL_BITS-1:0] cfg_sel = 4'h0;
  logic                  sclk;
  logic                  sdin;
  logic                  strobe;
  logic                  readback_output;
  logic                  data_oe;
  logic                  clk_oe;
  logic                  uart_mode;
  logic                  spi_mode;
  logic [`WORD_BITS-1:0] cfg_word;
  logic                  data_in = 1'b0;
  logic                  bclk_in = 1'b0;
  logic                  fsk4_mode = 1'b0;
  logic                  demod_bit = 1'b0;
  logic                  radio_data_out;
  logic                  bclk_out;
  logic                  ref_out;
  logic                  sync_det;
  logic                  tx_bit;
  logic [1:0]            fsk4_symbol;
  logic                  fsk4_valid;
  logic [1:0]            got_sym = 2'h0;
  int                    n_sym = 0;
  localparam logic [`RB_BITS-1:0] RB_PAT = 16'ha5c3;
  int                    err_total = 0;
  int                    n_compared = 0;

  // 25 MHz clock
  always #20 clk = ~clk;

  host_serial_model host (.clk(clk), .serial_clock(sclk), .serial_word_input(sdin),
    .latch_load_strobe(strobe));
  // Radio-side pins and demodulator bits are driven by the scenarios
  radio_serial_config_port i_radio_serial_config_port (.clk(clk), .rst_b(rst_b),
    .serial_clock(sclk), .serial_word_input(sdin), .latch_load_strobe(strobe),
    .chip_enable(chip_enable), .readback_output(readback_output),
    .radio_data_pin_in(data_in), .radio_data_pin_out(radio_data_out),
    .radio_data_pin_oe(data_oe),
    .radio_bit_clock_pin_in(bclk_in), .radio_bit_clock_pin_out(bclk_out),
    .radio_bit_clock_pin_oe(clk_oe), .divided_reference_output(ref_out),
    .sync_detect(sync_det),
    .radio_transmit(radio_transmit), .fsk4_mode(fsk4_mode), .demod_bit(demod_bit),
    .readback_value(readback_value), .cfg_sel(cfg_sel), .cfg_word(cfg_word),
    .uart_mode(uart_mode), .spi_mode(spi_mode), .tx_bit(tx_bit),
    .fsk4_symbol(fsk4_symbol), .fsk4_symbol_valid(fsk4_valid));

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Filter, latch and view stages take six clocks; eight leaves margin
  task automatic settle();
    repeat (8) @(posedge clk);
  endtask
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Clocks between two changes of the reference output
  task automatic t_ref(input int half);
    logic r;
    int   n;
    r = ref_out;
    n = 0;
    while (ref_out === r && n < 200) begin
      @(posedge clk);
      n++;
    end
    r = ref_out;
    n = 0;
    while (ref_out === r && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk("ref_half", half, n);
  endtask
  // Normal mode: reference divider, centred bit clock, data pin transmit
  task automatic t_normal();
    int n;
    n = 0;
    t_ref(`REF_HALF_CYC);
    chk("clk_oe", 32'h1, {31'h0, clk_oe});
    demod_bit <= 1'b1;
    while ((!bclk_out || n < 5) && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk("bclk_centre", 32'h1, {31'h0, n >= `BIT_CYCLES / 2 && n <= `BIT_CYCLES / 2 + 4});
    chk("data_out", 32'h1, {31'h0, radio_data_out});
    radio_transmit <= 1'b1;
    data_in        <= 1'b1;
    repeat (2 * `BIT_CYCLES) @(posedge clk);
    chk("tx_bit", 32'h1, {31'h0, tx_bit});
    radio_transmit <= 1'b0;
    data_in        <= 1'b0;
    demod_bit      <= 1'b0;
  endtask
  // One received bit per bit period; symbol strobes are caught while they stand
  task automatic feed(input logic b);
    demod_bit <= b;
    repeat (`BIT_CYCLES) begin
      @(posedge clk);
      if (fsk4_valid === 1'b1) begin
        n_sym++;
        got_sym = fsk4_symbol;
      end
    end
  endtask
  // Sync match sets the detect flag and restarts symbol pairing on the MSB
  task automatic t_sync();
    logic [`SYNC_BITS-1:0] sw;
    sw = 24'hd3917a;
    fsk4_mode <= 1'b1;
    host.write_word({sw, 4'h0, `SYNC_LATCH});
    settle();
    chk("sync_detect", 32'h0, {31'h0, sync_det});
    for (int i = `SYNC_BITS - 1; i >= 0; i--) begin
      if (i == 0) begin
        chk("sync_detect", 32'h0, {31'h0, sync_det});
      end
      feed(sw[i]);
    end
    chk("sync_detect", 32'h1, {31'h0, sync_det});
    n_sym = 0;
    feed(1'b1);
    feed(1'b0);
    chk("fsk4_count", 32'h1, n_sym);
    chk("fsk4_symbol", 32'h2, {30'h0, got_sym});
    host.write_word({sw, 4'h0, `SYNC_LATCH});
    settle();
    chk("sync_detect", 32'h0, {31'h0, sync_det});
    fsk4_mode <= 1'b0;
  endtask
  // Latch 5 must survive the later write to latch 0
  task automatic t_uart();
    host.write_word(32'h1234_5675);
    host.write_word(32'h1000_0000);
    cfg_sel <= 4'h5;
    settle();
    chk("uart_mode", 32'h1, {31'h0, uart_mode});
    chk("spi_mode", 32'h0, {31'h0, spi_mode});
    chk("cfg_word", 32'h1234_5675, cfg_word);
    settle();
    chk("data_oe", 32'h1, {31'h0, data_oe});
    chk("clk_oe", 32'h0, {31'h0, clk_oe});
    t_ref(`BIT_CYCLES / 2);
    // Data pin high, clock pin low: transmit data must come from the clock pin
    radio_transmit <= 1'b1;
    data_in        <= 1'b1;
    settle();
    chk("data_oe", 32'h0, {31'h0, data_oe});
    chk("clk_oe", 32'h0, {31'h0, clk_oe});
    repeat (2 * `BIT_CYCLES) @(posedge clk);
    chk("tx_bit", 32'h0, {31'h0, tx_bit});
    radio_transmit <= 1'b0;
    data_in        <= 1'b0;
  endtask
  // Field value 7 selects SPI, value 6 must not
  task automatic t_spi();
    host.write_word(32'h000e_000f);
    settle();
    chk("spi_mode", 32'h1, {31'h0, spi_mode});
    host.write_word(32'h000c_000f);
    cfg_sel <= 4'h0;
    settle();
    chk("spi_mode", 32'h0, {31'h0, spi_mode});
    chk("cfg_word", 32'h1000_0000, cfg_word);
  endtask
  // Sixteen bits MSB first, one per serial clock
  task automatic t_readback();
    readback_value <= RB_PAT;
    host.write_word(32'h0000_0007);
    settle();
    for (int i = 15; i >= 0; i--) begin
      chk("readback", {31'h0, RB_PAT[i]}, {31'h0, readback_output});
      if (i > 0) begin
        host.pulse(1'b0);
        host.hold(4);
      end
    end
  endtask
  // Power-down wipes latches; host reprograms after enable
  task automatic t_ce();
    cfg_sel <= 4'h5;
    chip_enable <= 1'b0;
    repeat (12) @(posedge clk);
    chk("uart_mode", 32'h0, {31'h0, uart_mode});
    chk("cfg_word", 32'h0, cfg_word);
    chip_enable <= 1'b1;
    settle();
    host.write_word(32'h1000_0000);
    settle();
    chk("uart_mode", 32'h1, {31'h0, uart_mode});
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    settle();
    t_normal();
    t_uart();
    t_spi();
    t_readback();
    t_ce();
    t_sync();
    stop_test();
  end
  // Run needs about 5000 clocks; cut a hang well beyond that
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    stop_test();
  end
endmodule

bind radio_serial_config_port radio_cfg_monitor i_mon (.clk(clk), .rst_b(rst_b),
  .latch_load_strobe(latch_load_strobe), .serial_clock(serial_clock),
  .chip_enable(chip_enable), .readback_output(readback_output),
  .radio_transmit(radio_transmit), .radio_data_pin_oe(radio_data_pin_oe),
  .radio_bit_clock_pin_oe(radio_bit_clock_pin_oe), .uart_mode(uart_mode),
  .spi_mode(spi_mode), .sync_detect(sync_detect), .cfg_word(cfg_word),
  .fsk4_symbol_valid(fsk4_symbol_valid));

`default_nettype wire
